// >>> bench/lvwr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lvwr_chk (
  input wire logic CLK, RST_B, POR_B, WR, RD, MONITOR_EN, WARN_IRQ, IRQ,
  input wire logic SUPPLY_BELOW_WARN, LOW_POWER_MODE,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA, RDATA,
  input wire logic [1:0] WARN_TRIP_SEL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wire logic sb = SUPPLY_BELOW_WARN;
  wire logic ww = WR && ADDR == lvwr_pkg::ADDR_WARN;
  wire logic rw = RD && ADDR == lvwr_pkg::ADDR_WARN;
  AST_ACK_RD: assert property ($past(RD) |-> !RDATA[6]) else $error("ack read");
  AST_RSVD: assert property ($past(rw) |-> RDATA[4:2] == 3'h0) else $error("rsvd");
  AST_SEL_RD: assert property ($past(rw) |-> RDATA[1:0] == $past(WARN_TRIP_SEL))
    else $error("sel read");
  AST_SEL_WR: assert property (ww |=> WARN_TRIP_SEL == $past(WDATA[1:0]))
    else $error("sel write");
  AST_IE_OFF: assert property (ww && !WDATA[5] |=> !WARN_IRQ) else $error("ie");
  // Supply equal now and 8 cycles earlier (cycles between unchecked), against a synchronised event racing the acknowledge
  AST_ACK: assert property (ww && WDATA[6] && sb == $past(sb, 8) |=> !WARN_IRQ)
    else $error("ack");
  AST_KEEP: assert property (POR_B && $past(POR_B) && !$past(WR) |->
    $stable(WARN_TRIP_SEL)) else $error("sel kept");
  AST_LP: assert property (LOW_POWER_MODE [*6] |-> !MONITOR_EN) else $error("monitor");
  cover property (WARN_IRQ);
  cover property (IRQ);
  cover property ($past(rw) && RDATA[7]);
endmodule : lvwr_chk
bind lvwr_regs lvwr_chk u_chk (.*);
`default_nettype wire

// >>> bench/test_lvwr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_lvwr_regs;
  logic CLK = 1'b0, RST_B = 1'b0, POR_B = 1'b0, WR = 1'b0, RD = 1'b0, REG_IN_RUN = 1'b0;
  logic SUPPLY_BELOW_WARN = 1'b1, LOW_POWER_MODE = 1'b0, MONITOR_EN, WARN_IRQ, IRQ;
  logic [9:0] ADDR = 10'h000;
  logic [7:0] WDATA = 8'h00, RDATA, v;
  logic [1:0] WARN_TRIP_SEL, DETECT_TRIP_SEL;
  logic [31:0] lfsr = 32'h40dc2e10;
  int error_cnt = 0, cmp_count = 0;
  wire logic [9:0] aw = lvwr_pkg::ADDR_WARN;
  lvwr_regs DUT (.*);
  initial forever #4 CLK = ~CLK;
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end
  endtask : chk
  task automatic finish_test;
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic wr(logic [9:0] a, logic [7:0] d);
    WR <= 1'b1; ADDR <= a; WDATA <= d;
    @(posedge CLK) WR <= 1'b0;
    @(posedge CLK);
  endtask : wr
  task automatic rd(logic [9:0] a, logic [7:0] e);
    RD <= 1'b1; ADDR <= a;
    @(posedge CLK) RD <= 1'b0;
    @(negedge CLK);
    chk("rdata", e, RDATA);
    @(posedge CLK);
  endtask : rd
  initial begin
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1; POR_B <= 1'b1;
    repeat (8) @(posedge CLK);
    rd(aw, 8'h80);
    wr(aw, 8'h9c);
    rd(aw, 8'h80);
    wr(aw, 8'h40);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr); v = {lfsr[7:2], i[1:0]} | 8'h40; REG_IN_RUN <= lfsr[9];
      wr(aw, v);
      rd(aw, v & 8'h23);
      wr(lvwr_pkg::ADDR_DETECT, lfsr[15:8]);
      rd(lvwr_pkg::ADDR_REG, {5'h00, lfsr[9], 2'h0});
      chk("detect", {6'h00, lfsr[9:8]}, {6'h00, DETECT_TRIP_SEL});
      rd(10'h3fc, 8'h00);
    end
    wr(aw, 8'h21);
    wr(lvwr_pkg::ADDR_IRQ_MASK, 8'h01);
    SUPPLY_BELOW_WARN <= 1'b0;
    repeat (8) @(posedge CLK);
    SUPPLY_BELOW_WARN <= 1'b1;
    repeat (8) @(posedge CLK);
    SUPPLY_BELOW_WARN <= 1'b0;
    repeat (8) @(negedge CLK);
    chk("irqs", 8'h03, {6'h00, WARN_IRQ, IRQ});
    wr(lvwr_pkg::ADDR_IRQ_MASK, 8'h00);
    @(negedge CLK) chk("irq", 8'h00, {7'h00, IRQ});
    rd(lvwr_pkg::ADDR_IRQ_STAT, 8'h01);
    rd(lvwr_pkg::ADDR_IRQ_STAT, 8'h00);
    wr(aw, 8'h61);
    @(negedge CLK) chk("warn_irq", 8'h00, {7'h00, WARN_IRQ});
    LOW_POWER_MODE <= 1'b1;
    repeat (8) @(posedge CLK);
    SUPPLY_BELOW_WARN <= 1'b1;
    repeat (8) @(negedge CLK);
    chk("monitor", 8'h00, {7'h00, MONITOR_EN});
    rd(aw, 8'h21);
    SUPPLY_BELOW_WARN <= 1'b0; LOW_POWER_MODE <= 1'b0; RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (8) @(posedge CLK);
    rd(aw, 8'h01);
    RST_B <= 1'b0; POR_B <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1; POR_B <= 1'b1;
    repeat (8) @(posedge CLK);
    rd(aw, 8'h00);
    finish_test;
  end
endmodule : test_lvwr_regs
`default_nettype wire

// >>> hdl/lvwr_pkg.sv
package lvwr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_WARN = 8'h01;
  localparam logic [7:0] IDX_REG = 8'h02;
  localparam logic [7:0] IDX_DETECT = 8'h10;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h11;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h12;
  localparam logic [9:0] ADDR_WARN = {IDX_WARN, 2'b00};
  localparam logic [9:0] ADDR_REG = {IDX_REG, 2'b00};
  localparam logic [9:0] ADDR_DETECT = {IDX_DETECT, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  // Warning register fields
  localparam int WARN_FLAG_BIT = 7;
  localparam int WARN_ACK_BIT = 6;
  localparam int WARN_IE_BIT = 5;
  localparam int WARN_SEL_LSB = 0;
  // Regulator register field
  localparam int REG_RUN_BIT = 2;
  // Reset values
  localparam logic [1:0] WARN_SEL_RST = 2'h0;
  localparam logic [1:0] DETECT_SEL_RST = 2'h0;
  localparam logic WARN_IE_RST = 1'b0;
  localparam logic IRQ_MASK_RST = 1'b0;
endpackage : lvwr_pkg

// >>> hdl/lvwr_regs.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Set warning flag on supply falling below warning trip, including right after reset.
// - Warning flag is read-only bit 7; one means warning seen.
// - Writing one to bit 6 clears the flag; zero does nothing.
// - Acknowledge bit is write-only and always reads zero.
// - Interrupt request while enable bit 5 and flag are both set.
// - Bits 4 to 2 of warning register read zero.
// - Two-bit trip select at bits 1:0 picks one of four levels.
// - Both warning and detect trip selects go to the analogue side.
// - Trip select is reset by power-on reset only.
// - Other warning bits reset by chip reset except low-leakage exit.
// - Monitoring is off in very-low-power or low-leakage modes.
// - Regulator register resets on chip reset except low-leakage exit.
// - Read-only regulator run status follows the regulator state input.
module lvwr_regs (
  // Clock and resets
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic POR_B,
  // Register port
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Analogue side
  input wire logic SUPPLY_BELOW_WARN,
  input wire logic REG_IN_RUN,
  input wire logic LOW_POWER_MODE,
  output logic [1:0] WARN_TRIP_SEL,
  output logic [1:0] DETECT_TRIP_SEL,
  output logic MONITOR_EN,
  // Interrupts
  output logic WARN_IRQ,
  output logic IRQ
);
  logic [2:0] below_sync_q;
  logic [2:0] mode_sync_q;
  logic [2:0] run_sync_q;
  logic below_q, mode_q, run_q, below_prev_q;
  logic flag_q, ie_q, irq_q, wirq_q, mask_q, stat_q, mon_q;
  logic [1:0] sel_q, dsel_q;
  logic [7:0] rdata_q;
  // The first stage of each synchroniser feeds only the second
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      below_sync_q <= 3'h0;
      mode_sync_q <= 3'h0;
      run_sync_q <= 3'h0;
    end else begin
      below_sync_q <= {below_sync_q[1:0], SUPPLY_BELOW_WARN};
      mode_sync_q <= {mode_sync_q[1:0], LOW_POWER_MODE};
      run_sync_q <= {run_sync_q[1:0], REG_IN_RUN};
    end
  end
  // A change counts once stages two and three agree
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      below_q <= 1'b0;
      mode_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      if (below_sync_q[2] == below_sync_q[1]) below_q <= below_sync_q[2];
      if (mode_sync_q[2] == mode_sync_q[1]) mode_q <= mode_sync_q[2];
      if (run_sync_q[2] == run_sync_q[1]) run_q <= run_sync_q[2];
    end
  end
  // Decode
  wire wr_warn = WR && (ADDR == lvwr_pkg::ADDR_WARN);
  wire wr_det = WR && (ADDR == lvwr_pkg::ADDR_DETECT);
  wire wr_mask = WR && (ADDR == lvwr_pkg::ADDR_IRQ_MASK);
  wire rd_stat = RD && (ADDR == lvwr_pkg::ADDR_IRQ_STAT);
  wire ack = wr_warn && WDATA[lvwr_pkg::WARN_ACK_BIT];
  // Monitoring suspended in low-power modes regardless of settings
  wire mon_active = !mode_q;
  // below_prev_q resets to 0, so a supply already low sets the flag after reset
  wire warn_event = mon_active && below_q && !below_prev_q;
  // Set wins over acknowledge; recovery alone never clears
  wire flag_d = warn_event ? 1'b1 : (ack ? 1'b0 : flag_q);
  wire stat_d = warn_event ? 1'b1 : (rd_stat ? 1'b0 : stat_q);
  // Request follows the enable as written in the same cycle, not one late
  wire ie_d = wr_warn ? WDATA[lvwr_pkg::WARN_IE_BIT] : ie_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      below_prev_q <= 1'b0;
      flag_q <= 1'b0;
      ie_q <= lvwr_pkg::WARN_IE_RST;
      stat_q <= 1'b0;
      mask_q <= lvwr_pkg::IRQ_MASK_RST;
      mon_q <= 1'b0;
    end else begin
      below_prev_q <= below_q && mon_active;
      flag_q <= flag_d;
      stat_q <= stat_d;
      ie_q <= ie_d;
      if (wr_mask) mask_q <= WDATA[0];
      mon_q <= mon_active;
    end
  end
  // Trip selects live only on power-on reset
  always_ff @(posedge CLK or negedge POR_B) begin
    if (!POR_B) begin
      sel_q <= lvwr_pkg::WARN_SEL_RST;
      dsel_q <= lvwr_pkg::DETECT_SEL_RST;
    end else begin
      if (wr_warn) sel_q <= WDATA[lvwr_pkg::WARN_SEL_LSB +: 2];
      if (wr_det) dsel_q <= WDATA[1:0];
    end
  end
  // Read mux
  wire [7:0] warn_rd = {flag_q, 1'b0, ie_q, 3'h0, sel_q};
  wire [7:0] reg_rd = {5'h00, run_q, 2'h0};
  wire [7:0] rd_mux =
    (ADDR == lvwr_pkg::ADDR_WARN) ? warn_rd :
    (ADDR == lvwr_pkg::ADDR_REG) ? reg_rd :
    (ADDR == lvwr_pkg::ADDR_DETECT) ? {6'h00, dsel_q} :
    (ADDR == lvwr_pkg::ADDR_IRQ_STAT) ? {7'h00, stat_q} :
    (ADDR == lvwr_pkg::ADDR_IRQ_MASK) ? {7'h00, mask_q} : 8'h00;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q <= 8'h00;
      wirq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= RD ? rd_mux : 8'h00;
      wirq_q <= ie_d && flag_d;
      irq_q <= mask_q && stat_d;
    end
  end
  assign RDATA = rdata_q;
  assign WARN_TRIP_SEL = sel_q;
  assign DETECT_TRIP_SEL = dsel_q;
  assign MONITOR_EN = mon_q;
  assign WARN_IRQ = wirq_q;
  assign IRQ = irq_q;
endmodule : lvwr_regs
`default_nettype wire
